// *** pkg/printer_port_regs.vh ***
// constants of the parallel printer port: register offsets, field positions, reset values
// assumes inclusion by bare name from design files of the printer port
`ifndef PRINTER_PORT_REGS_VH
`define PRINTER_PORT_REGS_VH

// ***********************************
// register offsets on reg_addr
// ***********************************
`define PP_OFS_DATA 2'h0
`define PP_OFS_STATUS 2'h1
`define PP_OFS_CONTROL 2'h2
`define PP_OFS_IOSEL 2'h3

// ***********************************
// control register fields
// ***********************************
`define PP_CTL_STROBE 0
`define PP_CTL_AUTOFEED 1
`define PP_CTL_RESTART 2
`define PP_CTL_CHOOSE 3
`define PP_CTL_IRQ_EN 4
`define PP_CTL_DIR_IN 5
`define PP_CTL_RESET 8'h04

// ***********************************
// status register fields
// ***********************************
`define PP_STS_IRQ 2
`define PP_STS_FAULT_N 3
`define PP_STS_ONLINE 4
`define PP_STS_PAPER_OUT 5
`define PP_STS_HANDSHAKE_N 6
`define PP_STS_BUSY_N 7

// ***********************************
// input-output select codes
// ***********************************
`define PP_IOSEL_OUT 8'hAA
`define PP_IOSEL_IN 8'h55
`define PP_IOSEL_OUT_RESET 1'b1

`endif

// *** src/pp_two_entry_buffer.v ***
// two-entry valid/ready buffer between host writes and the printer data latch
// assumes one clock and an active-high asynchronous reset
`timescale 1ns/10ps
`default_nettype none

module pp_two_entry_buffer #(
   parameter WIDTH = 8
) (
   // clock and reset
   input wire core_clk,
   input wire rst,
   // filling side
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   // draining side
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);

   reg [WIDTH-1:0] slot_q [0:1];
   reg wr_ptr_q;
   reg rd_ptr_q;
   reg [1:0] count_q;
   wire push;
   wire pop;

   // ***********************************
   // flags and pointers
   // ***********************************
   assign in_ready = (count_q != 2'h2);
   assign out_valid = (count_q != 2'h0);
   assign out_data = slot_q[rd_ptr_q];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         count_q <= 2'h0;
         slot_q[0] <= {WIDTH{1'b0}};
         slot_q[1] <= {WIDTH{1'b0}};
      end else begin
         if (push) begin
            slot_q[wr_ptr_q] <= in_data;
            wr_ptr_q <= ~wr_ptr_q;
         end
         if (pop) begin
            rd_ptr_q <= ~rd_ptr_q;
         end
         if (push & ~pop) begin
            count_q <= count_q + 2'h1;
         end else if (pop & ~push) begin
            count_q <= count_q - 2'h1;
         end
      end
   end

endmodule // pp_two_entry_buffer

`default_nettype wire

// *** src/printer_parallel_port.v ***
// parallel printer port: host register access and printer-side pins
// assumes every pin input is asynchronous to core_clk; the testbench resolves open-drain wires
`timescale 1ns/10ps
`default_nettype none
`include "printer_port_regs.vh"

// Behaviour
// - printer_fault_n is read in status; low means printer error.
// - printer_restart_n is open drain from control; low asks printer to initialise.
// - irq_latch_select low and irq enable set: printer_irq_n follows printer_handshake_n.
// - irq_latch_select high: interrupt held asserted until trailing edge of a host read.
// - printer_irq_n is high impedance until control bit 4 is set.
// - selected read places register chosen by reg_addr on host_data.
// - selected write stores host_data into register chosen by reg_addr.
// - written byte is latched and held on printer_data_bus in output mode.
// - paper_out is read in status as out-of-paper or general input.
// - read_active is high while the host performs a read.
// - reset returns all registers and outputs to their reset state.
// - printer_online is read in status as on-line or general input.
// - printer_choose_n driven by control bit 3; its pin level reads back in bit 3.
// - direction_mode_pin low uses select register, high uses control bit 5.
// - data_valid_pulse_n is an open-drain software-controlled strobe line.
module printer_parallel_port (
   // clock and reset
   input wire core_clk,
   input wire rst,
   // host bus
   input wire host_read_n,
   input wire host_write_n,
   input wire port_select_n,
   input wire [1:0] reg_addr,
   input wire [7:0] host_data_i,
   output reg [7:0] host_data_o,
   output wire host_data_oe,
   output reg read_active,
   output wire data_wr_ready,
   // printer data bus
   input wire [7:0] printer_data_bus_i,
   output reg [7:0] printer_data_bus_o,
   output wire printer_data_bus_oe,
   // printer status inputs
   input wire printer_fault_n,
   input wire printer_online,
   input wire paper_out,
   input wire printer_handshake_n,
   input wire printer_busy,
   // open-drain control lines
   input wire data_valid_pulse_n_i,
   output wire data_valid_pulse_n_o,
   output wire data_valid_pulse_n_oe,
   input wire auto_feed_n_i,
   output wire auto_feed_n_o,
   output wire auto_feed_n_oe,
   input wire printer_restart_n_i,
   output wire printer_restart_n_o,
   output wire printer_restart_n_oe,
   input wire printer_choose_n_i,
   output wire printer_choose_n_o,
   output wire printer_choose_n_oe,
   // interrupt
   input wire irq_latch_select,
   output wire printer_irq_n_o,
   output wire printer_irq_n_oe,
   // direction strap
   input wire direction_mode_pin
);

   localparam SW = 32;

   // ***********************************
   // pin synchroniser
   // ***********************************
   wire [SW-1:0] pins;
   reg [SW-1:0] s1_q;
   reg [SW-1:0] s2_q;
   reg [SW-1:0] s3_q;
   reg [SW-1:0] f_q;
   wire [SW-1:0] f_d;
   // pins idle at their inactive level, except printer_busy, paper_out and printer_online, which idle high, so reset does not look like a strobe
   localparam [SW-1:0] PIN_IDLE = 32'hE007FC00;

   assign pins = {host_read_n, host_write_n, port_select_n, reg_addr, host_data_i,
                  printer_fault_n, printer_online, paper_out, printer_handshake_n,
                  printer_busy, data_valid_pulse_n_i, auto_feed_n_i, printer_restart_n_i,
                  printer_choose_n_i, irq_latch_select, direction_mode_pin,
                  printer_data_bus_i};
   // a bit changes once the second and third stage agree
   assign f_d = (s2_q & s3_q) | (f_q & (s2_q | s3_q));

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s1_q <= PIN_IDLE;
         s2_q <= PIN_IDLE;
         s3_q <= PIN_IDLE;
         f_q <= PIN_IDLE;
      end else begin
         s1_q <= pins;
         s2_q <= s1_q;
         s3_q <= s2_q;
         f_q <= f_d;
      end
   end

   wire rd_n_f = f_q[31];
   wire wr_n_f = f_q[30];
   wire cs_n_f = f_q[29];
   wire [1:0] addr_f = f_q[28:27];
   wire [7:0] hdata_f = f_q[26:19];
   wire fault_n_f = f_q[18];
   wire online_f = f_q[17];
   wire paper_f = f_q[16];
   wire hs_n_f = f_q[15];
   wire busy_f = f_q[14];
   wire [3:0] od_pin_f = f_q[13:10];
   wire latch_sel_f = f_q[9];
   wire dir_pin_f = f_q[8];
   wire [7:0] pdata_f = f_q[7:0];

   // ***********************************
   // host access
   // ***********************************
   reg wr_act_q;
   reg [1:0] wr_addr_q;
   reg [7:0] wr_data_q;
   reg rd_act_q;
   reg [7:0] ctrl_q;
   reg iosel_out_q;
   reg irq_latched_q;
   reg hs_n_prev_q;
   reg [7:0] rd_mux;
   wire wr_act = ~wr_n_f & ~cs_n_f;
   wire rd_act = ~rd_n_f & ~cs_n_f;
   wire wr_done = wr_act_q & wr_n_f;
   wire rd_done = rd_act_q & ~rd_act;
   wire input_mode;
   wire buf_out_valid;
   wire [7:0] buf_out_data;
   wire irq_asserted;

   // direction from strap or select register
   assign input_mode = dir_pin_f ? ctrl_q[`PP_CTL_DIR_IN] : ~iosel_out_q;

   always @* begin
      case (addr_f)
         `PP_OFS_DATA: rd_mux = input_mode ? pdata_f : printer_data_bus_o;
         `PP_OFS_STATUS: begin
            rd_mux = 8'h00;
            rd_mux[`PP_STS_IRQ] = ~irq_asserted;
            rd_mux[`PP_STS_FAULT_N] = fault_n_f;
            rd_mux[`PP_STS_ONLINE] = online_f;
            rd_mux[`PP_STS_PAPER_OUT] = paper_f;
            rd_mux[`PP_STS_HANDSHAKE_N] = hs_n_f;
            rd_mux[`PP_STS_BUSY_N] = ~busy_f;
         end
         `PP_OFS_CONTROL: begin
            rd_mux = ctrl_q;
            // pin levels read back, low pin shows as a set bit, except restart, which reads back the pin level uninverted
            rd_mux[`PP_CTL_STROBE] = ~od_pin_f[3];
            rd_mux[`PP_CTL_AUTOFEED] = ~od_pin_f[2];
            rd_mux[`PP_CTL_RESTART] = od_pin_f[1];
            rd_mux[`PP_CTL_CHOOSE] = ~od_pin_f[0];
         end
         default: rd_mux = {7'h00, iosel_out_q};
      endcase
   end

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wr_act_q <= 1'b0;
         wr_addr_q <= 2'h0;
         wr_data_q <= 8'h00;
         rd_act_q <= 1'b0;
         read_active <= 1'b0;
         host_data_o <= 8'h00;
         ctrl_q <= `PP_CTL_RESET;
         iosel_out_q <= `PP_IOSEL_OUT_RESET;
      end else begin
         wr_act_q <= wr_act;
         rd_act_q <= rd_act;
         read_active <= rd_act;
         host_data_o <= rd_mux;
         if (wr_act) begin
            wr_addr_q <= addr_f;
            wr_data_q <= hdata_f;
         end
         if (wr_done) begin
            if (wr_addr_q == `PP_OFS_CONTROL) begin
               ctrl_q <= wr_data_q;
            end
            if (wr_addr_q == `PP_OFS_IOSEL) begin
               if (wr_data_q == `PP_IOSEL_OUT) begin
                  iosel_out_q <= 1'b1;
               end else if (wr_data_q == `PP_IOSEL_IN) begin
                  iosel_out_q <= 1'b0;
               end
            end
         end
      end
   end

   assign host_data_oe = read_active;

   // ***********************************
   // printer data path
   // ***********************************
   // the latch drains the buffer while the printer is not busy
   pp_two_entry_buffer #(
      .WIDTH(8)
   ) u_data_buf (
      .core_clk(core_clk),
      .rst(rst),
      .in_valid(wr_done & (wr_addr_q == `PP_OFS_DATA)),
      .in_ready(data_wr_ready),
      .in_data(wr_data_q),
      .out_valid(buf_out_valid),
      .out_ready(~busy_f),
      .out_data(buf_out_data)
   );

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         printer_data_bus_o <= 8'h00;
      end else if (buf_out_valid & ~busy_f) begin
         printer_data_bus_o <= buf_out_data;
      end
   end

   assign printer_data_bus_oe = ~rst & ~input_mode;

   // ***********************************
   // open-drain control lines
   // ***********************************
   assign data_valid_pulse_n_o = 1'b0;
   assign auto_feed_n_o = 1'b0;
   assign printer_restart_n_o = 1'b0;
   assign printer_choose_n_o = 1'b0;
   assign data_valid_pulse_n_oe = ~rst & ctrl_q[`PP_CTL_STROBE];
   assign auto_feed_n_oe = ~rst & ctrl_q[`PP_CTL_AUTOFEED];
   assign printer_restart_n_oe = ~rst & ~ctrl_q[`PP_CTL_RESTART];
   assign printer_choose_n_oe = ~rst & ctrl_q[`PP_CTL_CHOOSE];

   // ***********************************
   // printer interrupt
   // ***********************************
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irq_latched_q <= 1'b0;
         hs_n_prev_q <= 1'b1;
      end else begin
         hs_n_prev_q <= hs_n_f;
         // a new handshake edge wins over the clearing read
         if (hs_n_prev_q & ~hs_n_f) begin
            irq_latched_q <= 1'b1;
         end else if (rd_done) begin
            irq_latched_q <= 1'b0;
         end
      end
   end

   assign irq_asserted = latch_sel_f ? irq_latched_q : ~hs_n_f;
   assign printer_irq_n_o = ~irq_asserted;
   assign printer_irq_n_oe = ~rst & ctrl_q[`PP_CTL_IRQ_EN];

endmodule // printer_parallel_port

`default_nettype wire

// *** verification/pp_checker_assertions.sv ***
// checker of the printer port pin behaviour
// assumes it is bound onto printer_parallel_port
`timescale 1ns/10ps
`default_nettype none
module pp_checker (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // host side
   input wire logic host_read_n,
   input wire logic host_write_n,
   input wire logic port_select_n,
   input wire logic read_active,
   input wire logic host_data_oe,
   input wire logic data_wr_ready,
   // printer side
   input wire logic [7:0] printer_data_bus_o,
   input wire logic printer_data_bus_oe,
   input wire logic printer_busy,
   input wire logic printer_handshake_n,
   input wire logic data_valid_pulse_n_o,
   input wire logic data_valid_pulse_n_oe,
   input wire logic printer_restart_n_o,
   input wire logic printer_restart_n_oe,
   input wire logic printer_choose_n_o,
   input wire logic printer_choose_n_oe,
   // interrupt
   input wire logic irq_latch_select,
   input wire logic printer_irq_n_o,
   input wire logic printer_irq_n_oe
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   chk_reset_pins_idle: assert property (disable iff (1'b0) rst |-> data_wr_ready &&
      !(printer_data_bus_oe | printer_irq_n_oe | data_valid_pulse_n_oe | printer_restart_n_oe
      | printer_choose_n_oe)) else $error("pin driven during reset");
   chk_read_rise: assert property ((!host_read_n && !port_select_n)[*6] |-> read_active)
      else $error("read_active late");
   chk_read_fall: assert property (host_read_n[*6] |-> !read_active)
      else $error("read_active stuck");
   chk_data_oe: assert property (port_select_n[*6] |-> !host_data_oe)
      else $error("host data enable off read");
   chk_irq_follow: assert property ((!irq_latch_select && printer_irq_n_oe &&
      $stable(printer_handshake_n))[*6] |-> printer_irq_n_o == printer_handshake_n)
      else $error("irq not following handshake");
   chk_irq_held: assert property ((irq_latch_select && printer_irq_n_oe && !printer_irq_n_o
      && host_read_n && !read_active)[*3] |=> !printer_irq_n_o)
      else $error("latched irq cleared without read");
   chk_latch_held: assert property ((host_write_n && printer_busy)[*8] |=>
      $stable(printer_data_bus_o)) else $error("latch moved while busy");
   chk_open_drain: assert property (!data_valid_pulse_n_o && !printer_restart_n_o
      && !printer_choose_n_o) else $error("open drain pin driven high");
endmodule // pp_checker
`default_nettype wire

// *** verification/printer_model.sv ***
// behavioural printer at the far side of the port
// assumes open-drain wires are resolved by the bench
`timescale 1ns/10ps
`default_nettype none
module printer_model (
   // clock
   input wire logic core_clk,
   // lines from the port
   input wire logic strobe_n,
   input wire logic restart_n,
   input wire logic [7:0] data,
   // bench control
   input wire logic stall,
   // lines to the port, and the taken byte to the bench
   output logic busy,
   output logic handshake_n,
   output logic [7:0] took
);
   logic strobe_q = 1'b1;
   int cnt = 0;
   initial begin
      busy = 1'b0;
      handshake_n = 1'b1;
      took = 8'h00;
   end
   always @(posedge core_clk) begin
      strobe_q <= strobe_n;
      busy <= stall;
      if (!restart_n) begin
         took <= 8'h00;
         handshake_n <= 1'b1;
         cnt <= 0;
      end else if (strobe_q && !strobe_n) begin
         took <= data;
         handshake_n <= 1'b0;
         cnt <= 20;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end else begin
         handshake_n <= 1'b1;
         cnt <= 0;
      end
   end
endmodule // printer_model
`default_nettype wire

// *** verification/test_printer_parallel_port.sv ***
// self-checking bench of the parallel printer port
// assumes checker and printer model are compiled first
`timescale 1ns/10ps
`default_nettype none
module test_printer_parallel_port;
   logic core_clk, rst, rd_n, wr_n, sel_n, irq_sel, dir_pin, stall, fault_n, online, pe;
   logic [1:0] addr;
   logic [7:0] wdata, pd_val, hd_o, pd_o, took, ctl_m, lat_m, v;
   logic hd_oe, rd_act, wr_rdy, pd_oe, busy, hs_n, irq_o, irq_oe;
   logic stb_o, stb_oe, af_o, af_oe, rs_o, rs_oe, ch_o, ch_oe;
   logic [7:0] q[$];
   int n_mismatch = 0, checks_done = 0, i;
   wire logic stb_w = stb_oe ? stb_o : 1'b1;
   wire logic af_w = af_oe ? af_o : 1'b1;
   wire logic rs_w = rs_oe ? rs_o : 1'b1;
   wire logic ch_w = ch_oe ? ch_o : 1'b1;
   wire logic [7:0] pd_w = pd_oe ? pd_o : pd_val;
   printer_parallel_port u_printer_parallel_port (.core_clk(core_clk), .rst(rst),
      .host_read_n(rd_n), .host_write_n(wr_n), .port_select_n(sel_n), .reg_addr(addr),
      .host_data_i(wdata), .host_data_o(hd_o), .host_data_oe(hd_oe), .read_active(rd_act),
      .data_wr_ready(wr_rdy), .printer_data_bus_i(pd_w), .printer_data_bus_o(pd_o),
      .printer_data_bus_oe(pd_oe), .printer_fault_n(fault_n), .printer_online(online),
      .paper_out(pe), .printer_handshake_n(hs_n), .printer_busy(busy),
      .data_valid_pulse_n_i(stb_w), .data_valid_pulse_n_o(stb_o), .data_valid_pulse_n_oe(stb_oe),
      .auto_feed_n_i(af_w), .auto_feed_n_o(af_o), .auto_feed_n_oe(af_oe),
      .printer_restart_n_i(rs_w), .printer_restart_n_o(rs_o), .printer_restart_n_oe(rs_oe),
      .printer_choose_n_i(ch_w), .printer_choose_n_o(ch_o), .printer_choose_n_oe(ch_oe),
      .irq_latch_select(irq_sel), .printer_irq_n_o(irq_o), .printer_irq_n_oe(irq_oe),
      .direction_mode_pin(dir_pin));
   printer_model u_printer (.core_clk(core_clk), .strobe_n(stb_w), .restart_n(rs_w),
      .data(pd_w), .stall(stall), .busy(busy), .handshake_n(hs_n), .took(took));
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one selected strobe, held per the handshake spacing
   task automatic access(input logic wr, input logic [1:0] a, input logic [7:0] d);
      @(posedge core_clk);
      sel_n <= 1'b0;
      addr <= a;
      wdata <= d;
      if (wr) wr_n <= 1'b0;
      else rd_n <= 1'b0;
      repeat (7) @(posedge core_clk);
      v = hd_o;
      if (!wr) check("read_active", 8'h01, {7'h00, rd_act});
      wr_n <= 1'b1;
      rd_n <= 1'b1;
      sel_n <= 1'b1;
      repeat (9) @(posedge core_clk);
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      if (a == 2'h0 && q.size() < 2) q.push_back(d);
      access(1'b1, a, d);
      while (!stall && q.size() > 0) lat_m = q.pop_front();
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] exp, input string what);
      access(1'b0, a, 8'h00);
      check(what, exp, v);
   endtask
   task automatic wait_irq(input logic lvl);
      for (i = 0; i < 40 && irq_o !== lvl; i++) @(posedge core_clk);
      check("irq level", {7'h00, lvl}, {7'h00, irq_o});
      if (i == 40) tally_and_finish();
   endtask
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   initial begin
      v = $urandom(41597);
      {rst, rd_n, wr_n, sel_n, irq_sel, dir_pin, stall, fault_n, online, pe} = 10'h3C7;
      {addr, wdata, pd_val, lat_m} = 26'h0;
      repeat (12) @(posedge core_clk);
      check("bus oe in reset", 8'h00, {7'h00, pd_oe});
      rst <= 1'b0;
      repeat (6) @(posedge core_clk);
      rd(2'h2, 8'h04, "control reset");
      for (int k = 0; k < 4; k++) begin
         {fault_n, online, pe} <= 3'($urandom);
         access(1'b0, 2'h1, 8'h00);
         check("status", {~busy, hs_n, pe, online, fault_n, 3'h0}, v & 8'hF8);
         ctl_m = 8'($urandom) & 8'hCF;
         wr(2'h2, ctl_m);
         rd(2'h2, ctl_m, "control");
         check("pins", {4'h0, ~ctl_m[3], ctl_m[2], ~ctl_m[1], ~ctl_m[0]},
               {4'h0, ch_w, rs_w, af_w, stb_w});
      end
      wr(2'h2, 8'h04);
      wr(2'h0, 8'($urandom));
      check("latched", lat_m, pd_w);
      rd(2'h0, lat_m, "data");
      stall <= 1'b1;
      for (int k = 0; k < 3; k++) wr(2'h0, 8'($urandom));
      check("ready full", 8'h00, {7'h00, wr_rdy});
      wr(2'h0, 8'h3C);
      check("held", lat_m, pd_w);
      stall <= 1'b0;
      repeat (10) @(posedge core_clk);
      while (q.size() > 0) lat_m = q.pop_front();
      check("drained", lat_m, pd_w);
      pd_val <= 8'($urandom);
      wr(2'h3, 8'h55);
      check("iosel input", 8'h00, {7'h00, pd_oe});
      rd(2'h0, pd_val, "pin data");
      wr(2'h3, 8'h12);
      check("iosel ignored", 8'h00, {7'h00, pd_oe});
      wr(2'h3, 8'hAA);
      check("iosel output", 8'h01, {7'h00, pd_oe});
      dir_pin <= 1'b1;
      wr(2'h2, 8'h24);
      check("ctl input", 8'h00, {7'h00, pd_oe});
      check("irq off", 8'h00, {7'h00, irq_oe});
      for (int m = 0; m < 2; m++) begin
         irq_sel <= m[0];
         wr(2'h2, 8'h14);
         check("irq on", 8'h01, {7'h00, irq_oe});
         access(1'b0, 2'h1, 8'h00);
         check("irq idle", 8'h01, {7'h00, irq_o});
         wr(2'h2, 8'h15);
         check("printer took", lat_m, took);
         wait_irq(1'b0);
         if (m == 1) begin
            repeat (40) @(posedge core_clk);
            check("irq held", 8'h00, {7'h00, irq_o});
            access(1'b0, 2'h1, 8'h00);
         end
         wait_irq(1'b1);
      end
      tally_and_finish();
   end
endmodule // test_printer_parallel_port
bind printer_parallel_port pp_checker chk (.core_clk(core_clk), .rst(rst),
   .host_read_n(host_read_n), .host_write_n(host_write_n), .port_select_n(port_select_n),
   .read_active(read_active), .host_data_oe(host_data_oe), .data_wr_ready(data_wr_ready),
   .printer_data_bus_o(printer_data_bus_o), .printer_data_bus_oe(printer_data_bus_oe),
   .printer_busy(printer_busy), .printer_handshake_n(printer_handshake_n),
   .data_valid_pulse_n_o(data_valid_pulse_n_o), .data_valid_pulse_n_oe(data_valid_pulse_n_oe),
   .printer_restart_n_o(printer_restart_n_o), .printer_restart_n_oe(printer_restart_n_oe),
   .printer_choose_n_o(printer_choose_n_o), .printer_choose_n_oe(printer_choose_n_oe),
   .irq_latch_select(irq_latch_select), .printer_irq_n_o(printer_irq_n_o),
   .printer_irq_n_oe(printer_irq_n_oe));
`default_nettype wire
